/* rtl/sbu_pkg.sv */
`default_nettype none
package sbu_pkg;
  // ******************************************************************
  // Timing of the bus clock.
  // ******************************************************************
  localparam int unsigned CLK_FREQ_HZ      = 20000000;
  localparam int unsigned MIN_BUS_FREQ_HZ  = 10000;
  // Longest whole bus period at the slowest legal bus rate.
  localparam int unsigned MAX_PERIOD_CYC   = CLK_FREQ_HZ / MIN_BUS_FREQ_HZ;
  // Base tick of the bus clock period, in picoseconds.
  localparam int unsigned BASE_TICK_PS     = 271000;
  localparam int unsigned CLK_PERIOD_PS    = 1000000000 / (CLK_FREQ_HZ / 1000);
  // Base tick rounded up to whole core cycles, never below one.
  localparam int unsigned TICK_CYC_RAW     =
    (BASE_TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TICK_CYC         =
    (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;
  localparam int unsigned DIV_W            = 8;
  localparam logic [7:0]  DIV_RESET        = 8'hFF;
  localparam logic [7:0]  PEC_POLY         = 8'h07;
  localparam int unsigned BIT_CNT_W        = 4;
  localparam logic [3:0]  ACK_BIT          = 4'h8;

  // ******************************************************************
  // Carriers.
  // ******************************************************************
  typedef enum logic [1:0] {
    SBU_QUICK,
    SBU_SEND,
    SBU_RECV
  } sbu_proto_t;

  typedef struct packed {
    sbu_proto_t  proto;
    logic [6:0]  addr;
    logic        rw;
    logic [7:0]  data;
    logic        add_pec;
    logic [7:0]  pec;
  } sbu_req_t;

  typedef struct packed {
    logic        done;
    logic        nack;
    logic [7:0]  rx_data;
    logic [7:0]  rx_pec;
    logic        pec_ok;
  } sbu_rsp_t;
endpackage
`default_nettype wire

/* rtl/sbu_clk_sync.sv */
`default_nettype none
// ********************************************************************
// Bus clock generator with stretching and wired-AND synchronisation.
// ********************************************************************
module sbu_clk_sync (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             run,
  input  wire logic             hold_low,
  input  wire logic [7:0]       clock_divide_factor,
  input  wire logic             scl_in,
  output logic                  scl_oe,
  output logic                  rise_pulse,
  output logic                  fall_pulse,
  output logic                  scl_level
);
  localparam int unsigned CW = 20;

  logic          s1_r;
  logic          s2_r;
  logic          s3_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] half_cyc;
  logic          rose;
  logic          fell;
  logic          drive_nxt;

  // Half period: (factor + 1) ticks of the base rate, split low and high.
  assign half_cyc = CW'(((32'(clock_divide_factor) + 32'd1)
                   * sbu_pkg::TICK_CYC) >> 1) + CW'(1);  // R19 R1
  assign rose = s2_r & ~s3_r;
  assign fell = ~s2_r & s3_r;

  // Counter restarts on every observed edge of the real line level.
  assign cnt_nxt = (rose | fell) ? '0 :
                   (cnt_r == half_cyc) ? cnt_r : cnt_r + CW'(1);  // R21 R3 R4

  // Low timed from fall, and a hold only extends a low still driven,
  // so a released clock is never pulled again before it is seen high.
  // High timed from rise and the first finisher pulls low again.
  assign drive_nxt = !run ? 1'b0 :
                     !s2_r ? ((cnt_nxt != half_cyc) |
                              (hold_low & scl_oe)) :  // R7 R2 R5
                     (cnt_nxt == half_cyc);                          // R8

  // Two-stage synchroniser then edge history of the bus clock.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_r       <= 1'b1;
      s2_r       <= 1'b1;
      s3_r       <= 1'b1;
      cnt_r      <= '0;
      scl_oe     <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
      scl_level  <= 1'b1;
    end else begin
      s1_r       <= scl_in;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      cnt_r      <= cnt_nxt;
      scl_oe     <= drive_nxt;  // R6
      rise_pulse <= rose;
      fall_pulse <= fell;
      scl_level  <= s2_r;
    end
  end
endmodule
`default_nettype wire

/* rtl/sbu_master.sv */
`default_nettype none
// Summary of operation
// R1: Any stretching party keeps the bus clock at or above 10 kHz; the master's stretch input holds the low with no limit.
// R2: Stretching of a low phase starts before minimum low time expires.
// R3: Slave may stretch low during any bit, including before acknowledge.
// R4: Slave may hold clock low between bytes after acknowledging.
// R5: Master may stretch low between bytes or anywhere within a byte.
// R6: Clock is driven open-drain; bus level is wired-AND of drivers.
// R7: On falling edge each party times low, releases when done.
// R8: After rise all time high; first finisher pulls clock low.
// R9: Sender of last data byte appends one error code byte.
// R10: Error code is CRC-8 over address, command, data bytes only.
// R11: Error code polynomial is x^8 + x^2 + x + 1.
// R12: Device passes error code bytes as data; software computes them.
// R13: Error-code slave accepts both forms and refuses bad codes.
// R14: Error-code slave transmitter supplies code on extra clocks.
// R15: Correct code in capability read sets error-check-enabled flag.
// R16: Quick command: direction bit is the command, no data byte.
// R17: Send byte: one command byte follows address, 256 encodings.
// R18: Receive byte: slave returns one byte, master refuses it.
// R19: Master clock period is (divide factor + 1) times 271 ns; the code times ticks of TICK_CYC core cycles (300 ns) plus synchroniser delay.
// R20: Acknowledge: transmitter releases data, receiver drives low.
// R21: Intervals are timed from observed line edges, not own drive.
module sbu_master (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire sbu_pkg::sbu_req_t req,
  input  wire logic [7:0]       clock_divide_factor,
  input  wire logic             pec_checked,
  input  wire logic             stretch,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  scl_out,
  output logic                  scl_oe,
  output logic                  sda_out,
  output logic                  sda_oe,
  output logic                  busy,
  output sbu_pkg::sbu_rsp_t     rsp,
  output logic                  error_check_enabled_flag
);
  // ******************************************************************
  // Transfer sequencer states.
  // ******************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BYTE,
    ST_STOP_A,
    ST_STOP_B
  } sbu_state_t;

  sbu_state_t        st_r;
  sbu_pkg::sbu_req_t req_r;
  logic [7:0]  sh_r;
  logic [3:0]  bit_r;
  logic [1:0]  idx_r;
  logic        sda_oe_r;
  logic        run_r;
  logic        busy_r;
  logic        nack_r;
  logic        d1_r;
  logic        d2_r;
  logic [7:0]  rx_r;
  logic [7:0]  rxp_r;
  logic [7:0]  crc_r;
  logic        done_r;
  logic        pef_r;
  logic        okp_r;

  logic        rise;
  logic        fall;
  logic        gen_oe;
  logic        is_read;
  logic        last_byte;
  logic        rx_phase;
  logic        ack_slot;
  logic [7:0]  next_byte;
  logic [7:0]  crc_after;
  logic        start_rw;
  logic        rx_next;
  logic        bit_last;
  logic        code_slot;

  // ******************************************************************
  // Notes on timing.
  // ******************************************************************
  // Both lines pass two flip-flops and the edge pulses one more, so
  // the sequencer sees each clock edge about three core cycles after
  // the pins show it.
  // Data changes follow an observed fall and so settle well inside the
  // low phase, which is itself timed from that same fall.
  // The stretch input can only lengthen a low phase that is still
  // being driven; once released, the clock is not pulled again until
  // it has been seen high, so no other party ever sees a double fall.
  // A refused address or byte ends the frame with a stop at the next
  // low phase, and software reads the refusal from the response.
  // The code check runs beside the transfer and only marks the
  // capability flag after a receive whose code byte matched.
  // Bytes sent after the address are taken verbatim from the request, so a code
  // byte supplied by software goes out exactly as given.

  // ******************************************************************
  // Bus clock engine.
  // ******************************************************************
  sbu_clk_sync u_clk (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .run                 (run_r),
    .hold_low            (stretch),
    .clock_divide_factor (clock_divide_factor),
    .scl_in              (scl_in),
    .scl_oe              (gen_oe),
    .rise_pulse          (rise),
    .fall_pulse          (fall),
    .scl_level           ()
  );

  // One CRC-8 step of a full byte, polynomial x^8+x^2+x+1.
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ sbu_pkg::PEC_POLY) : (r << 1);  // R11
    end
    return r;
  endfunction

  // ******************************************************************
  // Framing decode.
  // ******************************************************************
  assign is_read  = (req_r.proto == sbu_pkg::SBU_RECV) |
                    ((req_r.proto == sbu_pkg::SBU_QUICK) & req_r.rw);
  // Byte 0 is the address, byte 1 command or returned data, byte 2 code.
  assign last_byte = (req_r.proto == sbu_pkg::SBU_QUICK) ? 1'b1 :  // R16
                     req_r.add_pec ? (idx_r == 2'd2) : (idx_r == 2'd1);  // R9
  assign rx_phase  = (idx_r != 2'd0) &
                     (req_r.proto == sbu_pkg::SBU_RECV);
  assign ack_slot  = (bit_r == sbu_pkg::ACK_BIT);
  // Command byte and code byte come from software unchanged.
  assign next_byte = (idx_r == 2'd0) ? req_r.data :
                     req_r.pec;  // R12
  // Running code over address and data bytes only, for the flag check.
  assign crc_after = crc8(crc_r, sh_r);  // R10
  // Direction bit of the address byte for the request at the pins.
  assign start_rw  = (req.proto == sbu_pkg::SBU_RECV) |
                     ((req.proto == sbu_pkg::SBU_QUICK) & req.rw);
  // Every byte after the address comes from the slave in a receive.
  assign rx_next   = (req_r.proto == sbu_pkg::SBU_RECV);
  // Last data bit of a byte, just before the acknowledge slot.
  assign bit_last  = (bit_r == 4'h7);
  // Code byte slot, which is left out of the running code.
  assign code_slot = (idx_r == 2'd2);

  // ******************************************************************
  // Sequencer: one bit per observed low phase of the clock.
  // ******************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_r     <= ST_IDLE;
      req_r    <= '0;
      sh_r     <= 8'h00;
      bit_r    <= 4'h0;
      idx_r    <= 2'd0;
      sda_oe_r <= 1'b0;
      run_r    <= 1'b0;
      busy_r   <= 1'b0;
      nack_r   <= 1'b0;
      rx_r     <= 8'h00;
      rxp_r    <= 8'h00;
      crc_r    <= 8'h00;
      done_r   <= 1'b0;
      okp_r    <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (start) begin
            req_r    <= req;
            sh_r     <= {req.addr, start_rw};
            sda_oe_r <= 1'b1;  // Start: data falls while clock high.
            busy_r   <= 1'b1;
            nack_r   <= 1'b0;
            idx_r    <= 2'd0;
            bit_r    <= 4'h0;
            crc_r    <= 8'h00;
            st_r     <= ST_START;
          end
        end
        ST_START: begin
          run_r <= 1'b1;
          if (fall) begin
            sda_oe_r <= ~sh_r[7];
            st_r     <= ST_BYTE;
          end
        end
        ST_BYTE: begin
          if (rise) begin
            if (ack_slot) begin
              nack_r <= d2_r & ~rx_phase;  // R20
            end else begin
              sh_r <= {sh_r[6:0], d2_r};
            end
          end else if (fall) begin
            if (ack_slot) begin
              bit_r <= 4'h0;
              if (rx_phase) begin
                if (idx_r == 2'd1) rx_r <= sh_r;
                else rxp_r <= sh_r;
              end
              crc_r <= code_slot ? crc_r : crc_after;  // R10
              okp_r <= code_slot & rx_phase & (crc_r == sh_r);  // R15
              if (last_byte | nack_r) begin
                sda_oe_r <= 1'b1;
                st_r     <= ST_STOP_A;
              end else begin
                idx_r    <= idx_r + 2'd1;
                sh_r     <= rx_next ? 8'hFF : next_byte;  // R17
                sda_oe_r <= ~rx_next & ~next_byte[7];
              end
            end else if (bit_last) begin
              bit_r <= sbu_pkg::ACK_BIT;
              // Acknowledge a returned byte unless it closes the frame.
              sda_oe_r <= rx_phase & ~last_byte;  // R18
            end else begin
              bit_r    <= bit_r + 4'h1;
              sda_oe_r <= ~rx_phase & ~sh_r[7];
            end
          end
        end
        ST_STOP_A: begin
          if (rise) st_r <= ST_STOP_B;
        end
        ST_STOP_B: begin
          run_r    <= 1'b0;
          sda_oe_r <= 1'b0;  // Stop: data rises while clock high.
          busy_r   <= 1'b0;
          done_r   <= 1'b1;
          st_r     <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Data line synchroniser; only the second stage is used above.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      d1_r <= 1'b1;
      d2_r <= 1'b1;
    end else begin
      d1_r <= sda_in;
      d2_r <= d1_r;
    end
  end

  // Flag set from a good capability read or software's own check.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pef_r <= 1'b0;
    end else if (pec_checked | (done_r & okp_r & ~nack_r)) begin
      pef_r <= 1'b1;  // R15
    end
  end

  // ******************************************************************
  // Registered outputs.
  // ******************************************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      busy    <= 1'b0;
      rsp     <= '0;
      error_check_enabled_flag <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe  <= gen_oe;  // R6
      sda_out <= 1'b0;
      sda_oe  <= sda_oe_r;
      busy    <= busy_r | start;
      rsp     <= '{done: done_r, nack: nack_r, rx_data: rx_r,
                   rx_pec: rxp_r, pec_ok: okp_r};
      error_check_enabled_flag <= pef_r;
    end
  end
endmodule
`default_nettype wire

/* dv/sbu_master_assertions.sv */
`default_nettype none
// ****************************************************************
// Checker on the pins of the bus master.
// ****************************************************************
module sbu_master_assertions (
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              start,
  input wire sbu_pkg::sbu_req_t req,
  input wire logic [7:0]        clock_divide_factor,
  input wire logic              pec_checked,
  input wire logic              scl_in,
  input wire logic              scl_out,
  input wire logic              scl_oe,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic              busy,
  input wire sbu_pkg::sbu_rsp_t rsp,
  input wire logic              error_check_enabled_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap_r;
  logic [7:0]  nrise_r;
  logic [7:0]  want_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Counts cycles since the last rise of the clock line.
  always_ff @(posedge core_clk) begin
    if (!rstn || $rose(scl_in)) gap_r <= 16'h0001;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end

  // Counts clock pulses of a frame and the number the request needs.
  always_ff @(posedge core_clk) begin
    if (!rstn || (start && !busy)) nrise_r <= 8'h00;
    else if ($rose(scl_in)) nrise_r <= nrise_r + 8'h01;
    if (start && !busy) want_r <= (req.proto == sbu_pkg::SBU_QUICK) ?
      8'h0A : (req.add_pec ? 8'h1C : 8'h13);
  end

  a_pins_drive_low:
    assert property (!scl_out && !sda_out) else $error("pin not low");
  a_idle_bus_free:
    assert property (!busy && !$past(busy) |-> !scl_oe && !sda_oe)
    else $error("bus held while idle");
  a_pull_after_high:
    assert property ($rose(scl_oe) |-> $past(scl_in))
    else $error("clock pulled while line low");
  a_wait_line_low:
    assert property (busy && !scl_oe && !scl_in |=> !scl_oe)
    else $error("clock pulled again before rise");
  a_period_floor:
    assert property ($rose(scl_in) && nrise_r != 8'h00 &&
      nrise_r + 8'h01 < want_r |-> int'(gap_r) + 1 >=
      (int'(clock_divide_factor) + 1) * sbu_pkg::TICK_CYC)
    else $error("bus clock period too short");
  a_rate_floor:
    assert property (busy && nrise_r != 8'h00 |->
      gap_r <= 16'(sbu_pkg::MAX_PERIOD_CYC))
    else $error("bus clock below minimum rate");
  a_pulse_count:
    assert property (rsp.done && !rsp.nack |-> nrise_r == want_r)
    else $error("wrong clock pulse count");
  a_done_one_cycle:
    assert property (rsp.done |=> !rsp.done) else $error("done too long");
  a_start_sets_busy:
    assert property (start && !busy |=> busy) else $error("start ignored");
  a_flag_on_check:
    assert property (pec_checked |-> ##2 error_check_enabled_flag)
    else $error("flag not set");
  a_flag_sticky:
    assert property (error_check_enabled_flag |=> error_check_enabled_flag)
    else $error("flag dropped");
endmodule

bind sbu_master sbu_master_assertions i_chk (
  .core_clk, .rstn, .start, .req, .clock_divide_factor, .pec_checked,
  .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .busy, .rsp,
  .error_check_enabled_flag
);
`default_nettype wire

/* dv/sbu_slave_model.sv */
`default_nettype none
// ****************************************************************
// Behavioural bus slave with clock stretching and error codes.
// ****************************************************************
module sbu_slave_model (
  input  wire logic       core_clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  input  wire logic [7:0] tx_pec,
  input  wire logic [3:0] stretch_cyc,
  input  wire logic       nack_addr,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      last_rx,
  output logic            m_nack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [3:0] st = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] txr = 8'h00;
  wire logic [3:0] nxt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;

  // Released data line and clean flags before the first frame.
  initial begin
    sda_oe = 1'b0;
    m_nack = 1'b0;
    last_rx = 8'h00;
  end

  // Open-drain clock hold, bounded so the bus rate stays legal.
  assign scl_oe = (st != 4'h0);

  // Tracks start, bits and acknowledge slots from the line levels.
  always @(posedge core_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (st != 4'h0) st <= st - 4'h1;
    if (scl && scl_q && sda_q && !sda) begin
      cnt <= 4'hF;
      first <= 1'b1;
      rd <= 1'b0;
    end
    if (scl && !scl_q) begin
      if (cnt < 4'h8) sh <= {sh[6:0], sda};
      else if (rd && !sda_oe) begin
        m_nack <= sda;
        rd <= !sda;
        txr <= tx_pec;
      end
    end
    if (!scl && scl_q) begin
      cnt <= nxt;
      if (nxt == 4'h0) st <= stretch_cyc;
      if (nxt == 4'h8 && !rd) begin
        sda_oe <= !(first && nack_addr);
        last_rx <= sh;
        first <= 1'b0;
        txr <= tx_byte;
        if (first) rd <= sh[0] && !nack_addr;
      end else begin
        sda_oe <= rd && nxt != 4'h8 && !txr[3'h7 - nxt[2:0]];
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Clock, pins and devices.
  // ****************************************************************
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              start = 1'b0;
  logic              stretch = 1'b0;
  logic              pec_checked = 1'b0;
  logic              nack_addr = 1'b0;
  logic [7:0]        div = 8'h00;
  logic [7:0]        tx_byte = 8'h00;
  logic [7:0]        tx_pec = 8'h00;
  logic [7:0]        t, last_rx;
  logic [3:0]        st_cyc = 4'h0;
  logic              flag, busy, m_scl, m_sda, s_scl, s_sda, m_nack, bad;
  logic              exp_flag = 1'b0;
  sbu_pkg::sbu_req_t req = '0;
  sbu_pkg::sbu_req_t r;
  sbu_pkg::sbu_rsp_t rsp;
  integer            seed = 32'h06F1E8DB;
  integer            seed_s = 32'h06F1E8DB;
  int                failures = 0;
  int                n_checks = 0;
  int                cyc = 0;
  wire logic         scl = !(m_scl || s_scl);
  wire logic         sda = !(m_sda || s_sda);

  always #25 core_clk = ~core_clk;

  // Random holds of the master's own clock low phase.
  always @(posedge core_clk) stretch <= rstn && ($random(seed_s) % 8 == 0);

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      print_verdict();
    end
  end

  sbu_master i_dut (
    .core_clk, .rstn, .start, .req, .clock_divide_factor (div),
    .pec_checked, .stretch, .scl_in (scl), .sda_in (sda), .scl_out (),
    .scl_oe (m_scl), .sda_out (), .sda_oe (m_sda), .busy, .rsp,
    .error_check_enabled_flag (flag)
  );
  sbu_slave_model i_slave (
    .core_clk, .scl, .sda, .tx_byte, .tx_pec, .stretch_cyc (st_cyc),
    .nack_addr, .scl_oe (s_scl), .sda_oe (s_sda), .last_rx, .m_nack
  );

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Error code over two bytes, polynomial x^8 + x^2 + x + 1.
  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^
      ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // Random frames of all three protocols, then the flag.
  // ****************************************************************
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("flag at reset", 8'h00, {7'h00, flag});
    for (int k = 0; k < 30; k++) begin
      r.proto = sbu_pkg::sbu_proto_t'(k % 3);
      r.addr = $random(seed);
      r.rw = $random(seed);
      r.data = $random(seed);
      r.add_pec = (k % 3 != 0) && r.data[0];
      r.pec = crc({r.addr, 1'b0, r.data});
      t = $random(seed);
      // A quick read carries no data, so the slave must leave data high.
      if (k % 3 == 0) t[7] = 1'b1;
      bad = (k % 5 == 4);
      req <= r;
      start <= 1'b1;
      div <= 8'(k % 8);
      st_cyc <= r.data[7:4];
      tx_byte <= t;
      tx_pec <= crc({r.addr, 1'b1, t}) ^ {7'h00, bad};
      nack_addr <= (k == 29);
      @(posedge core_clk);
      start <= 1'b0;
      for (int n = 0; rsp.done !== 1'b1; n++) begin
        if (n == 8000) begin
          failures++;
          print_verdict();
        end
        @(posedge core_clk);
      end
      chk("nack", {7'h00, k == 29}, {7'h00, rsp.nack});
      if (k == 29) continue;
      if (r.proto == sbu_pkg::SBU_QUICK)
        chk("quick byte", {r.addr, r.rw}, last_rx);
      else if (r.proto == sbu_pkg::SBU_SEND)
        chk("send byte", r.add_pec ? r.pec : r.data, last_rx);
      else begin
        chk("recv byte", t, rsp.rx_data);
        chk("master nack", 8'h01, {7'h00, m_nack});
        if (r.add_pec) begin
          chk("recv code", tx_pec, rsp.rx_pec);
          chk("code ok", {7'h00, !bad}, {7'h00, rsp.pec_ok});
          if (!bad) exp_flag = 1'b1;
        end
      end
    end
    chk("flag from read", {7'h00, exp_flag}, {7'h00, flag});
    pec_checked <= 1'b1;
    @(posedge core_clk);
    pec_checked <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("flag set", 8'h01, {7'h00, flag});
    print_verdict();
  end
endmodule
`default_nettype wire
